// ==== sfe_defines.vh ====
`ifndef SFE_DEFINES_VH
`define SFE_DEFINES_VH

// ********************************************************
// command opcodes
// ********************************************************
`define SFE_OP_WREN   8'h06
`define SFE_OP_WRDI   8'h04
`define SFE_OP_RDSR   8'h05
`define SFE_OP_READ   8'h03
`define SFE_OP_FREAD  8'h0b
`define SFE_OP_DREAD  8'h3b
`define SFE_OP_PP     8'h02
`define SFE_OP_SE     8'h20
`define SFE_OP_BE32   8'h52
`define SFE_OP_BE64   8'hd8
`define SFE_OP_CE_A   8'h60
`define SFE_OP_CE_B   8'hc7

// ********************************************************
// array organisation (address bits per unit, last address byte index, erased value)
// ********************************************************
`define SFE_PAGE_W    8
`define SFE_SECT_W    12
`define SFE_BLK32_W   15
`define SFE_BLK64_W   16
`define SFE_ADDR_LAST 2'h2
`define SFE_ERASED    8'hff

// ********************************************************
// output bit counter reload at the first falling edge of a byte
// ********************************************************
`define SFE_LAST_SGL  3'h7
`define SFE_LAST_DUAL 3'h6

`endif

// ==== sfe_host.sv ====
`timescale 1ns/1ns
// ********************
// host controller model
// ********************
module sfe_host (
    // system
    input  wire core_clk,
    // link
    output reg  sclk,
    output reg  cs_n,
    output wire si_pin,
    // device pins
    input  wire z_out,
    input  wire z_oe_n,
    input  wire o_out,
    input  wire o_oe_n
);
    reg  mode3, si_q, drv, tgl, odd;
    wire so_pin;
    // lane zero release
    // a released pin shows a moving pattern, never the last value
    assign si_pin = !z_oe_n ? z_out : (drv ? si_q : tgl);
    assign so_pin = !o_oe_n ? o_out : tgl;
    initial begin
        {mode3, si_q, tgl, odd, sclk} = 5'h0;
        {drv, cs_n} = 2'h3;
    end
    always @(negedge core_clk)
        tgl <= ~tgl;
    task wait_n(input integer n);
        repeat (n) @(negedge core_clk);
    endtask
    task sel(input m3);
        mode3 = m3;
        sclk = m3;
        wait_n(20);
        cs_n = 1'b0;
        wait_n(6);
    endtask
    task bit_x(input si, input rel, output s0, output s1);
        sclk = 1'b0;
        si_q = si;
        drv = !rel;
        wait_n(6);
        sclk = 1'b1;
        s0 = si_pin;
        s1 = so_pin;
        odd = !odd;
        // highs of 6 and 7 cycles average a 125 ns period
        wait_n(odd ? 7 : 6);
    endtask
    task tx(input [7:0] v);
        integer i;
        reg a, c;
        for (i = 7; i >= 0; i = i - 1)
            bit_x(v[i], 1'b0, a, c);
    endtask
    task rx(input dual, output [7:0] v);
        integer i;
        reg a, c;
        for (i = 7; i >= 0; i = i - 1) begin
            bit_x(1'b0, dual, a, c);
            v[i] = c;
            if (dual) begin
                i = i - 1;
                v[i] = a;
            end
        end
    endtask
    task hdr(input [7:0] op, input [23:0] a);
        tx(op);
        tx(a[23:16]);
        tx(a[15:8]);
        tx(a[7:0]);
    endtask
    task desel;
        sclk = mode3;
        wait_n(6);
        cs_n = 1'b1;
        wait_n(20);
    endtask
endmodule

// ==== sfe_mem.v ====
`timescale 1ns/1ns

// ********************************************************
// simple dual-port memory, registered read data
// ********************************************************
module sfe_mem #(
    parameter DW = 8,
    parameter AW = 8
) (
    // clock
    input  wire          clk,
    // write side
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    // read side
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rd_q
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rd_q <= mem[raddr];
    end
endmodule

// ==== sfe_spi_front.v ====
// How it works
// - input bits are taken on rising serial clock, outputs change on falling.
// - either idle clock level (mode 0 or 3) works at chip select fall.
// - opcode 3b returns read data two bits per clock.
// - in dual read the data input pin drives lane zero, output pin lane one.
// - programming goes through a 256-byte page buffer, wrapping in the page.
// - erase covers a 4K sector, a 32K or 64K block, or the whole array.
// - command, address and data move most significant bit first.
// - write-type commands run only if chip select rises on a byte boundary.
`timescale 1ns/1ns
`include "sfe_defines.vh"

module sfe_spi_front #(
    parameter ADDR_W = 17
) (
    // system
    input  wire core_clk,
    input  wire rst,
    // serial link
    input  wire sclk,
    input  wire cs_n,
    input  wire dual_lane_zero_in,
    output wire dual_lane_zero_out,
    output wire dual_lane_zero_oe_n,
    output wire dual_lane_one_out,
    output wire dual_lane_one_oe_n,
    // status
    output wire write_latch,
    output wire array_busy
);
    // ********************************************************
    // states
    // ********************************************************
    localparam S_IDLE  = 3'h0;
    localparam S_CMD   = 3'h1;
    localparam S_ADDR  = 3'h2;
    localparam S_DUMMY = 3'h3;
    localparam S_DOUT  = 3'h4;
    localparam S_DIN   = 3'h5;
    localparam S_STAT  = 3'h6;
    localparam S_HOLD  = 3'h7;

    localparam E_IDLE  = 2'h0;
    localparam E_PRD   = 2'h1;
    localparam E_PWR   = 2'h2;
    localparam E_ERS   = 2'h3;

    localparam PAGE_N  = 1 << `SFE_PAGE_W;

    // ********************************************************
    // pin synchronisers and edge finding
    // ********************************************************
    reg [2:0] sclk_sq;
    reg [2:0] cs_sq;
    reg [1:0] din_sq;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_sq <= 3'h0;
            cs_sq   <= 3'h7;
            din_sq  <= 2'h0;
        end else begin
            sclk_sq <= {sclk_sq[1:0], sclk};
            cs_sq   <= {cs_sq[1:0], cs_n};
            din_sq  <= {din_sq[0], dual_lane_zero_in};
        end
    end

    wire sclk_rise = sclk_sq[1] & ~sclk_sq[2] & ~cs_sq[1];
    wire sclk_fall = ~sclk_sq[1] & sclk_sq[2] & ~cs_sq[1];
    wire cs_fall   = ~cs_sq[1] & cs_sq[2];
    wire cs_rise   = cs_sq[1] & ~cs_sq[2];

    // ********************************************************
    // link state
    // ********************************************************
    reg  [2:0]        st_q;
    reg  [2:0]        bit_q;
    reg  [1:0]        abyte_q;
    reg  [7:0]        sh_q;
    reg  [7:0]        cmd_q;
    reg  [23:0]       addr_q;
    reg  [7:0]        osh_q;
    reg  [2:0]        ocnt_q;
    reg               lane0_q;
    reg               lane0_oe_n_q;
    reg               lane1_q;
    reg               lane1_oe_n_q;
    reg               wel_q;
    reg  [PAGE_N-1:0] pv_q;
    reg  [1:0]        eng_q;
    reg  [ADDR_W-1:0] eidx_q;
    reg  [ADDR_W-1:0] ebase_q;
    reg  [ADDR_W-1:0] emask_q;

    wire [7:0] arr_rd;
    wire [7:0] buf_rd;
    wire       busy      = (eng_q != E_IDLE);
    wire [7:0] next_byte = {sh_q[6:0], din_sq[1]};
    wire       byte_done = sclk_rise & (bit_q == 3'h7);
    wire       is_dual   = (cmd_q == `SFE_OP_DREAD);
    wire [7:0] stat_byte = {6'h00, wel_q, busy};
    wire       whole     = (bit_q == 3'h0);
    wire       is_erase  = (cmd_q == `SFE_OP_SE) | (cmd_q == `SFE_OP_BE32) |
                           (cmd_q == `SFE_OP_BE64) |
                           (cmd_q == `SFE_OP_CE_A) | (cmd_q == `SFE_OP_CE_B);

    wire [ADDR_W-1:0] all_ones = {ADDR_W{1'b1}};
    wire [ADDR_W-1:0] ers_mask =
        (cmd_q == `SFE_OP_SE)   ? all_ones >> (ADDR_W - `SFE_SECT_W)  :
        (cmd_q == `SFE_OP_BE32) ? all_ones >> (ADDR_W - `SFE_BLK32_W) :
        (cmd_q == `SFE_OP_BE64) ? all_ones >> (ADDR_W - `SFE_BLK64_W) :
        all_ones;
    wire [ADDR_W-1:0] page_mask = all_ones >> (ADDR_W - `SFE_PAGE_W);

    // ********************************************************
    // command, address and data sequencing
    // ********************************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q    <= S_IDLE;
            bit_q   <= 3'h0;
            abyte_q <= 2'h0;
            sh_q    <= 8'h00;
            cmd_q   <= 8'h00;
            addr_q  <= 24'h000000;
            pv_q    <= {PAGE_N{1'b0}};
        end else if (cs_rise) begin
            st_q <= S_IDLE;
        end else if (cs_fall) begin
            // start clean whatever the clock level
            st_q  <= S_CMD;
            bit_q <= 3'h0;
        end else if (sclk_rise) begin
            bit_q <= bit_q + 3'h1;
            sh_q  <= next_byte;
            if (bit_q == 3'h7) begin
                case (st_q)
                    S_CMD: begin
                        cmd_q   <= next_byte;
                        abyte_q <= 2'h0;
                        case (next_byte)
                            `SFE_OP_RDSR: st_q <= S_STAT;
                            `SFE_OP_READ, `SFE_OP_FREAD, `SFE_OP_DREAD,
                            `SFE_OP_PP, `SFE_OP_SE, `SFE_OP_BE32,
                            `SFE_OP_BE64: st_q <= busy ? S_HOLD : S_ADDR;
                            default: st_q <= S_HOLD;
                        endcase
                    end
                    S_ADDR: begin
                        addr_q  <= {addr_q[15:0], next_byte};
                        abyte_q <= abyte_q + 2'h1;
                        if (abyte_q == `SFE_ADDR_LAST) begin
                            case (cmd_q)
                                `SFE_OP_READ: st_q <= S_DOUT;
                                `SFE_OP_FREAD,
                                `SFE_OP_DREAD: st_q <= S_DUMMY;
                                `SFE_OP_PP: begin
                                    st_q <= S_DIN;
                                    pv_q <= {PAGE_N{1'b0}};
                                end
                                default: st_q <= S_HOLD;
                            endcase
                        end
                    end
                    S_DUMMY: begin
                        st_q <= S_DOUT;
                    end
                    S_DIN: begin
                        pv_q[addr_q[7:0]] <= 1'b1;
                        addr_q[7:0]       <= addr_q[7:0] + 8'h01;
                    end
                    default: begin
                        st_q <= st_q;
                    end
                endcase
            end
        end else if (sclk_fall && st_q == S_DOUT && ocnt_q == 3'h0) begin
            addr_q <= addr_q + 24'h000001;
        end
    end

    // ********************************************************
    // output lanes
    // ********************************************************
    reg [7:0] out_byte;
    always @* begin
        out_byte = osh_q;
        if (ocnt_q == 3'h0) begin
            out_byte = (st_q == S_STAT) ? stat_byte : arr_rd;
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            osh_q        <= 8'h00;
            ocnt_q       <= 3'h0;
            lane0_q      <= 1'b0;
            lane0_oe_n_q <= 1'b1;
            lane1_q      <= 1'b0;
            lane1_oe_n_q <= 1'b1;
        end else if (cs_sq[1]) begin
            // lanes released whenever chip select is high
            ocnt_q       <= 3'h0;
            lane0_oe_n_q <= 1'b1;
            lane1_oe_n_q <= 1'b1;
        end else if (sclk_fall && (st_q == S_DOUT || st_q == S_STAT)) begin
            // outputs move on the falling edge
            lane1_q      <= out_byte[7];
            lane1_oe_n_q <= 1'b0;
            if (is_dual && st_q == S_DOUT) begin
                // input pin turns into lane zero
                lane0_q      <= out_byte[6];
                lane0_oe_n_q <= 1'b0;
                osh_q        <= {out_byte[5:0], 2'b00};
                ocnt_q       <= (ocnt_q == 3'h0) ? `SFE_LAST_DUAL :
                                ocnt_q - 3'h2;
            end else begin
                osh_q  <= {out_byte[6:0], 1'b0};
                ocnt_q <= (ocnt_q == 3'h0) ? `SFE_LAST_SGL :
                          ocnt_q - 3'h1;
            end
        end
    end

    // ********************************************************
    // commit and program / erase engine
    // ********************************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wel_q   <= 1'b0;
            eng_q   <= E_IDLE;
            eidx_q  <= {ADDR_W{1'b0}};
            ebase_q <= {ADDR_W{1'b0}};
            emask_q <= {ADDR_W{1'b0}};
        end else begin
            if (cs_rise && whole && !busy) begin
                if (st_q == S_HOLD && cmd_q == `SFE_OP_WREN) begin
                    wel_q <= 1'b1;
                end else if (st_q == S_HOLD && cmd_q == `SFE_OP_WRDI) begin
                    wel_q <= 1'b0;
                end else if (st_q == S_DIN && wel_q && (|pv_q)) begin
                    wel_q   <= 1'b0;
                    eng_q   <= E_PRD;
                    eidx_q  <= {ADDR_W{1'b0}};
                    ebase_q <= addr_q[ADDR_W-1:0] & ~page_mask;
                    emask_q <= page_mask;
                end else if (st_q == S_HOLD && wel_q && is_erase) begin
                    wel_q   <= 1'b0;
                    eng_q   <= E_ERS;
                    eidx_q  <= {ADDR_W{1'b0}};
                    ebase_q <= addr_q[ADDR_W-1:0] & ~ers_mask;
                    emask_q <= ers_mask;
                end
            end
            case (eng_q)
                E_PRD: begin
                    eng_q <= E_PWR;
                end
                E_PWR, E_ERS: begin
                    if (eidx_q == emask_q) begin
                        eng_q <= E_IDLE;
                    end else begin
                        eidx_q <= eidx_q + {{(ADDR_W-1){1'b0}}, 1'b1};
                        eng_q  <= (eng_q == E_PWR) ? E_PRD : E_ERS;
                    end
                end
                default: begin
                    // idle holds, so a commit above is never overridden
                end
            endcase
        end
    end

    // programming only clears bits, so old data is anded with new
    wire [7:0] prog_byte = pv_q[eidx_q[7:0]] ? buf_rd : `SFE_ERASED;
    wire [7:0] arr_wdata = (eng_q == E_ERS) ? `SFE_ERASED :
                           (arr_rd & prog_byte);
    wire       arr_we    = (eng_q == E_ERS) | (eng_q == E_PWR);
    wire [ADDR_W-1:0] eng_addr = ebase_q | eidx_q;
    wire [ADDR_W-1:0] arr_raddr = busy ? eng_addr : addr_q[ADDR_W-1:0];
    wire       buf_we    = byte_done & (st_q == S_DIN);

    sfe_mem #(.DW(8), .AW(ADDR_W)) u_array (
        .clk   (core_clk),
        .we    (arr_we),
        .waddr (eng_addr),
        .wdata (arr_wdata),
        .raddr (arr_raddr),
        .rd_q  (arr_rd)
    );

    sfe_mem #(.DW(8), .AW(`SFE_PAGE_W)) u_page (
        .clk   (core_clk),
        .we    (buf_we),
        .waddr (addr_q[7:0]),
        .wdata (next_byte),
        .raddr (eidx_q[7:0]),
        .rd_q  (buf_rd)
    );

    reg busy_q;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy;
        end
    end

    assign dual_lane_zero_out  = lane0_q;
    assign dual_lane_zero_oe_n = lane0_oe_n_q;
    assign dual_lane_one_out   = lane1_q;
    assign dual_lane_one_oe_n  = lane1_oe_n_q;
    assign write_latch         = wel_q;
    assign array_busy          = busy_q;
endmodule

// ==== sfe_spi_front_asserts.sv ====
`timescale 1ns/1ns
// ********************
// port checker
// ********************
module sfe_spi_front_asserts (
    // system
    input wire core_clk,
    input wire rst,
    // serial link
    input wire sclk,
    input wire cs_n,
    input wire dual_lane_zero_in,
    input wire dual_lane_zero_out,
    input wire dual_lane_zero_oe_n,
    input wire dual_lane_one_out,
    input wire dual_lane_one_oe_n,
    // status
    input wire write_latch,
    input wire array_busy
);
    reg [15:0] busy_len_q;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // saturates so a whole-array erase cannot wrap to a short span
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            busy_len_q <= 16'h0;
        else if (!array_busy)
            busy_len_q <= 16'h0;
        else if (busy_len_q != 16'hffff)
            busy_len_q <= busy_len_q + 16'h1;
    end
    oe_idle_a: assert property (
        cs_n [*8] |-> dual_lane_zero_oe_n && dual_lane_one_oe_n)
        else $error("lane enabled while deselected");
    oe_pair_a: assert property (
        !dual_lane_zero_oe_n |-> !dual_lane_one_oe_n)
        else $error("lane zero driven without lane one");
    zero_start_a: assert property (
        $fell(dual_lane_zero_oe_n) |-> !cs_n && !sclk)
        else $error("lane zero enabled outside a low clock");
    one_edge_a: assert property (
        $changed(dual_lane_one_out) && !dual_lane_one_oe_n &&
        !$past(dual_lane_one_oe_n) |-> !sclk && !$past(sclk, 2))
        else $error("lane one changed away from a falling edge");
    zero_edge_a: assert property (
        $changed(dual_lane_zero_out) && !dual_lane_zero_oe_n &&
        !$past(dual_lane_zero_oe_n) |-> !sclk && !$past(sclk, 2))
        else $error("lane zero changed away from a falling edge");
    busy_start_a: assert property (
        $rose(array_busy) |-> !write_latch && cs_n)
        else $error("busy began with latch set or selected");
    wel_commit_a: assert property (
        $changed(write_latch) |-> cs_n && $past(cs_n))
        else $error("write latch moved inside a transaction");
    busy_span_a: assert property (
        $fell(array_busy) |-> busy_len_q >= 16'h1f4)
        else $error("busy span shorter than a page program");
    cover property (!dual_lane_zero_oe_n);
    cover property ($rose(array_busy));
    cover property ($rose(write_latch));
    cover property (!cs_n && sclk && dual_lane_zero_in);
endmodule

bind sfe_spi_front sfe_spi_front_asserts u_chk (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .dual_lane_zero_in(dual_lane_zero_in),
    .dual_lane_zero_out(dual_lane_zero_out),
    .dual_lane_zero_oe_n(dual_lane_zero_oe_n),
    .dual_lane_one_out(dual_lane_one_out),
    .dual_lane_one_oe_n(dual_lane_one_oe_n),
    .write_latch(write_latch), .array_busy(array_busy));

// ==== sfe_spi_front_bench.sv ====
`timescale 1ns/1ns
`include "sfe_defines.vh"
// ********************
// bench
// ********************
module sfe_spi_front_bench;
    reg        core_clk, rst, x0, x1;
    wire       sclk, cs_n, si_pin, z_out, z_oe_n, o_out, o_oe_n;
    wire       write_latch, array_busy;
    integer    failures, comparisons;
    reg  [7:0] b;
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;
    sfe_spi_front #(.ADDR_W(16)) uut (
        .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .dual_lane_zero_in(si_pin), .dual_lane_zero_out(z_out),
        .dual_lane_zero_oe_n(z_oe_n), .dual_lane_one_out(o_out),
        .dual_lane_one_oe_n(o_oe_n), .write_latch(write_latch),
        .array_busy(array_busy));
    sfe_host host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n),
        .si_pin(si_pin), .z_out(z_out), .z_oe_n(z_oe_n),
        .o_out(o_out), .o_oe_n(o_oe_n));
    task end_of_test;
        $display("%0d compares, %0d mismatches", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk1(input got, input exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task chk8(input [7:0] got, input [7:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task op1(input [7:0] op);
        host.sel(1'b0);
        host.tx(op);
        host.desel;
    endtask
    task rdsr(input [7:0] exp);
        host.sel(1'b1);
        host.tx(`SFE_OP_RDSR);
        repeat (2) begin
            host.rx(1'b0, b);
            chk8(b, exp);
        end
        host.desel;
    endtask
    task rd(input [7:0] op, input m3, input [23:0] a, input [31:0] exp);
        integer i;
        host.sel(m3);
        host.hdr(op, a);
        if (op != `SFE_OP_READ)
            host.tx(8'h00);
        for (i = 3; i >= 0; i = i - 1) begin
            host.rx(op == `SFE_OP_DREAD, b);
            chk8(b, exp[i*8 +: 8]);
        end
        host.desel;
    endtask
    task wait_idle;
        integer n;
        n = 0;
        while (array_busy !== 1'b0 && n < 70000) begin
            @(negedge core_clk);
            n = n + 1;
        end
        chk1(array_busy, 1'b0);
    endtask
    task prog(input [23:0] a, input [15:0] d);
        op1(`SFE_OP_WREN);
        host.sel(1'b0);
        host.hdr(`SFE_OP_PP, a);
        host.tx(d[15:8]);
        host.tx(d[7:0]);
        host.desel;
        chk1(array_busy, 1'b1);
        wait_idle;
    endtask
    task erase(input [7:0] op, input [23:0] a);
        op1(`SFE_OP_WREN);
        host.sel(1'b1);
        host.hdr(op, a);
        host.desel;
        rdsr(8'h01);
        wait_idle;
    endtask
    task t_status;
        chk1(o_oe_n & z_oe_n, 1'b1);
        chk1(write_latch | array_busy, 1'b0);
        op1(`SFE_OP_WREN);
        chk1(write_latch, 1'b1);
        rdsr(8'h02);
        op1(`SFE_OP_WRDI);
        chk1(write_latch, 1'b0);
        $display("status test done");
    endtask
    task t_erase_prog;
        erase(`SFE_OP_BE32, 24'h000000);
        prog(24'h001100, 16'ha53c);
        prog(24'h0011ff, 16'h1122);
        prog(24'h000fff, 16'h5a66);
        rd(`SFE_OP_READ, 1'b1, 24'h0011fe, 32'hff11ffff);
        rd(`SFE_OP_FREAD, 1'b0, 24'h0010ff, 32'hff203cff);
        rd(`SFE_OP_DREAD, 1'b1, 24'h0010ff, 32'hff203cff);
        rd(`SFE_OP_DREAD, 1'b0, 24'h000f00, 32'h66ffffff);
        erase(`SFE_OP_SE, 24'h001234);
        rd(`SFE_OP_READ, 1'b0, 24'h000fff, 32'h5affffff);
        rd(`SFE_OP_FREAD, 1'b1, 24'h0011fe, 32'hffffffff);
        $display("erase and program test done");
    endtask
    task t_refuse;
        op1(`SFE_OP_WREN);
        host.sel(1'b0);
        host.hdr(`SFE_OP_PP, 24'h000100);
        host.tx(8'h00);
        repeat (3) host.bit_x(1'b1, 1'b0, x0, x1);
        host.desel;
        chk1(write_latch, 1'b1);
        chk1(array_busy, 1'b0);
        host.sel(1'b1);
        host.hdr(`SFE_OP_CE_A, 24'h000000);
        host.bit_x(1'b1, 1'b0, x0, x1);
        host.desel;
        chk1(array_busy, 1'b0);
        op1(`SFE_OP_WRDI);
        host.sel(1'b0);
        host.hdr(`SFE_OP_BE64, 24'h000000);
        host.desel;
        chk1(array_busy, 1'b0);
        rd(`SFE_OP_READ, 1'b1, 24'h000100, 32'hffffffff);
        rd(`SFE_OP_FREAD, 1'b0, 24'h000ffe, 32'hff5affff);
        $display("refusal test done");
    endtask
    // mid-run reset while deselected must drop the latch
    task t_reset;
        op1(`SFE_OP_WREN);
        chk1(write_latch, 1'b1);
        rst = 1'b1;
        repeat (5) @(negedge core_clk);
        chk1(write_latch, 1'b0);
        chk1(o_oe_n & z_oe_n, 1'b1);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        rdsr(8'h00);
        $display("reset test done");
    endtask
    initial begin
        failures = 0;
        comparisons = 0;
        rst = 1'b1;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        t_status;
        t_erase_prog;
        t_refuse;
        t_reset;
        end_of_test;
    end
    // the erases dominate the run, well under this span
    initial begin
        #1000000;
        failures = failures + 1;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test;
    end
endmodule
